// ### inc/fcs_pkg.sv
package fcs_pkg;
  localparam int NUM_CHAN = 4;
  // tone each detector channel answers to, in hz (index 0 = channel_one)
  localparam int TONE_CHANNEL_ONE_HZ = 1250;
  localparam int TONE_CHANNEL_TWO_HZ = 1850;
  localparam int TONE_CHANNEL_THREE_HZ = 1350;
  localparam int TONE_CHANNEL_FOUR_HZ = 1950;
  localparam logic [3:0] TX_RESET_VALUE = 4'h0;
  localparam logic [3:0] RX_RESET_VALUE = 4'h1;
  localparam logic [3:0] SEL_ALL_OFF_N = 4'hf;
  localparam int SYNC_STAGES = 2;
endpackage

// ### design/fcs_sync_edge.sv
// two-stage synchroniser with a rise and fall pulse on the second stage
module fcs_sync_edge (
  // clock, reset and enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // asynchronous level
  input wire logic async_i,
  // synchronised level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import fcs_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } fcs_sync_s;

  fcs_sync_s st;
  fcs_sync_s next_st;

  always_comb begin
    next_st = st;
    if (en_i) begin
      next_st.meta = async_i;
      next_st.sync = st.meta;
      next_st.last = st.sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.sync;
  assign rise_o = en_i & st.sync & ~st.last;
  assign fall_o = en_i & ~st.sync & st.last;
endmodule // fcs_sync_edge

// ### design/fcs_select_latch.sv
// Overview of operation
// (R1) tone detections act only while function enable is high.
// (R2) upstream raises function enable only after recognising the guard tone.
// (R3) channel_two detect input is active low while 1850 hz is heard.
// (R4) inverted detect makes a tx latch clock pulse setting that tx flop.
// (R5) tx element select outputs are the inverse of the tx flops.
// (R6) setting one tx flop clears the other three.
// (R7) a rising tx flop pulses the rx latch setting the same rx channel.
// (R8) rx flop holds until reset or another channel is latched.
// (R9) rx select output is gated rx flop, inverted, so active low.
// (R10) keyed supply falling pulses the tx clock, clearing all tx flops.
// (R11) end of keying leaves the rx latch unchanged.
// (R12) new tx channel re-latches rx to the matching channel.
// (R13) power-on reset selects rx channel_one.
// (R14) four detectors: 1250, 1850, 1350 and 1950 hz channels.
// (R15) power-on reset leaves all tx flops low.
// (R16) inputs are synchronised; latch clocks are single-cycle edge pulses.
module fcs_select_latch (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // tone detectors, active low, index 0 = channel_one
  input wire logic [fcs_pkg::NUM_CHAN-1:0] tone_detect_n_i,
  // control from tone control module
  input wire logic function_enable_i,
  input wire logic keyed_supply_i,
  // channel element selects, active low
  output logic [fcs_pkg::NUM_CHAN-1:0] tx_select_n_o,
  output logic [fcs_pkg::NUM_CHAN-1:0] rx_select_n_o,
  // latch state for observation
  output logic [fcs_pkg::NUM_CHAN-1:0] tx_latch_o,
  output logic [fcs_pkg::NUM_CHAN-1:0] rx_latch_o
);
  import fcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [NUM_CHAN-1:0] det_level;
  logic [NUM_CHAN-1:0] det_rise;
  logic fen_level;
  logic key_fall;

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_det
    // detector active low: invert before edge detect (R3) (R14)
    fcs_sync_edge u_det (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .en_i(ce_i),
      .async_i(~tone_detect_n_i[g]),
      .level_o(det_level[g]),
      .rise_o(det_rise[g]),
      .fall_o()
    );
  end

  fcs_sync_edge u_fen (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(ce_i),
    .async_i(function_enable_i),
    .level_o(fen_level),
    .rise_o(),
    .fall_o()
  );

  logic key_level;
  fcs_sync_edge u_key (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(ce_i),
    .async_i(keyed_supply_i),
    .level_o(key_level),
    .rise_o(),
    .fall_o(key_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [NUM_CHAN-1:0] tx;
    logic [NUM_CHAN-1:0] rx;
    logic [NUM_CHAN-1:0] tx_sel_n;
    logic [NUM_CHAN-1:0] rx_sel_n;
  } fcs_state_s;

  fcs_state_s st;
  fcs_state_s next_st;

  // lowest index wins if two detections rise together, keeping one-hot
  function automatic logic [NUM_CHAN-1:0] pick_one(input logic [NUM_CHAN-1:0] v);
    logic [NUM_CHAN-1:0] r;
    r = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  logic [NUM_CHAN-1:0] tx_clk_set;
  logic [NUM_CHAN-1:0] tx_rise;
  logic [NUM_CHAN-1:0] tx_after;
  logic [NUM_CHAN-1:0] rx_after;

  always_comb begin
    next_st = st;
    // gate detections by function enable (R1) (R16)
    tx_clk_set = pick_one(det_rise & {NUM_CHAN{fen_level}}); // (R4)
    tx_after = st.tx;
    if (|tx_clk_set) begin
      tx_after = tx_clk_set; // (R6)
    end else if (key_fall) begin
      tx_after = TX_RESET_VALUE; // (R10)
    end
    // rx latch clocked only by a rising tx flop (R7) (R12); tx clear leaves it (R11)
    tx_rise = tx_after & ~st.tx;
    rx_after = st.rx;
    if (|tx_rise) begin
      rx_after = tx_rise; // (R8)
    end
    if (ce_i) begin
      next_st.tx = tx_after;
      next_st.rx = rx_after;
      next_st.tx_sel_n = ~tx_after; // (R5)
      // gated then inverted to give the grounding select (R9)
      next_st.rx_sel_n = ~(rx_after & {NUM_CHAN{1'b1}});
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st.tx <= TX_RESET_VALUE; // (R15)
      st.rx <= RX_RESET_VALUE; // (R13)
      st.tx_sel_n <= SEL_ALL_OFF_N;
      st.rx_sel_n <= ~RX_RESET_VALUE;
    end else begin
      st <= next_st;
    end
  end

  assign tx_select_n_o = st.tx_sel_n;
  assign rx_select_n_o = st.rx_sel_n;
  assign tx_latch_o = st.tx;
  assign rx_latch_o = st.rx;
endmodule // fcs_select_latch

// ### tb/fcs_checker.sv
module fcs_checker (
  input wire logic clk_i, nrst_i, ce_i, function_enable_i, keyed_supply_i,
  input wire logic [3:0] tone_detect_n_i, tx_select_n_o, rx_select_n_o, tx_latch_o, rx_latch_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // keying drops with no channel tone around it
  sequence key_end;
    $fell(keyed_supply_i) && (&tone_detect_n_i) ##1 (&tone_detect_n_i) [*2];
  endsequence
  sequence tx_new;
    $changed(tx_latch_o) && tx_latch_o != 4'h0;
  endsequence
  AST_RESET: assert property (disable iff (1'b0) !nrst_i |=> tx_latch_o == 4'h0 && rx_latch_o == 4'h1)
    else $error("reset state wrong");
  AST_TX_INV: assert property (tx_select_n_o == ~tx_latch_o) else $error("tx select");
  AST_RX_INV: assert property (rx_select_n_o == ~rx_latch_o) else $error("rx select");
  AST_TX_ONEHOT: assert property ($onehot0(tx_latch_o)) else $error("tx not one-hot");
  AST_RX_ONEHOT: assert property ($onehot(rx_latch_o)) else $error("rx not one-hot");
  AST_RX_FOLLOW: assert property (tx_new |-> rx_latch_o == tx_latch_o) else $error("rx not following");
  AST_RX_HOLD: assert property ($changed(rx_latch_o) |-> tx_new) else $error("rx moved alone");
  AST_RX_KEEP: assert property (tx_latch_o == 4'h0 |-> $stable(rx_latch_o)) else $error("rx lost");
  AST_FEN_GATE: assert property (!function_enable_i [*4] |-> not tx_new) else $error("tone taken");
  AST_KEY_CLEAR: assert property (key_end |=> tx_latch_o == 4'h0) else $error("tx not cleared");
endmodule // fcs_checker

// ### tb/fcs_tone_model.sv
module fcs_tone_model (
  input wire logic clk_i,
  output logic [3:0] tone_detect_n_o,
  output logic function_enable_o,
  output logic keyed_supply_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tone_detect_n_o = 4'hf;
    function_enable_o = 1'b0;
    keyed_supply_o = 1'b0;
  end
  // guard=0 models a tone sent without its guard tone
  task automatic send(input int ch, input bit guard);
    @(negedge clk_i) function_enable_o = guard;
    repeat (2) @(negedge clk_i);
    tone_detect_n_o[ch] = 1'b0;
    repeat (6) @(negedge clk_i);
    tone_detect_n_o[ch] = 1'b1;
    function_enable_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic key(input bit v);
    @(negedge clk_i) keyed_supply_o = v;
    repeat (5) @(negedge clk_i);
  endtask
endmodule // fcs_tone_model

// ### tb/four_channel_select_latch_test.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module four_channel_select_latch_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] td_n, tx_n, rx_n, tx_l, rx_l;
  logic fen, key;
  logic ce = 1'b1;
  int bad_count = 0, comparisons = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
  fcs_select_latch DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .tone_detect_n_i(td_n),
    .function_enable_i(fen), .keyed_supply_i(key), .tx_select_n_o(tx_n), .rx_select_n_o(rx_n),
    .tx_latch_o(tx_l), .rx_latch_o(rx_l));
  fcs_tone_model PM (.clk_i(clk_i), .tone_detect_n_o(td_n), .function_enable_o(fen), .keyed_supply_o(key));
  task automatic expect_state(input logic [3:0] t, input logic [3:0] r);
    `CHK(tx_l, t)
    `CHK(tx_n, ~t)
    `CHK(rx_l, r)
    `CHK(rx_n, ~r)
  endtask
  // each select changes channel without unkeying first
  task automatic test_select();
    PM.key(1'b1);
    // ends on channel_three so the held rx latch differs from its reset value
    for (int i = 0; i < 4; i++) begin
      PM.send((i + 3) % 4, 1'b1);
      expect_state(4'h1 << ((i + 3) % 4), 4'h1 << ((i + 3) % 4));
    end
  endtask
  task automatic test_key_end();
    PM.key(1'b0);
    expect_state(4'h0, 4'h4);
  endtask
  task automatic test_refused();
    PM.send(2, 1'b0);
    expect_state(4'h0, 4'h4);
  endtask
  // clock enable low must freeze synchronisers and latches alike
  task automatic test_freeze();
    ce = 1'b0;
    PM.send(0, 1'b1);
    expect_state(4'h0, 4'h4);
    ce = 1'b1;
    repeat (4) @(negedge clk_i);
    expect_state(4'h0, 4'h4);
  endtask
  task automatic test_reset_again();
    PM.send(1, 1'b1);
    expect_state(4'h2, 4'h2);
    nrst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    expect_state(4'h0, 4'h1);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    expect_state(4'h0, 4'h1);
    test_select();
    test_key_end();
    test_refused();
    test_freeze();
    test_reset_again();
    report_and_stop();
  end
endmodule // four_channel_select_latch_test
bind fcs_select_latch fcs_checker CHKR (.clk_i, .nrst_i, .ce_i, .function_enable_i, .keyed_supply_i,
  .tone_detect_n_i, .tx_select_n_o, .rx_select_n_o, .tx_latch_o, .rx_latch_o);
